/* File: rtl/supervisor_defines.svh */
// Notes on behaviour
// RULE1: Undervoltage asserts both resets at once.
// RULE2: After undervoltage, hold reset one stretch period.
// RULE3: Manual reset low keeps reset asserted.
// RULE4: Manual reset release adds one stretch period.
// RULE5: Kick level stuck past timeout triggers reset.
// RULE6: Every kick edge restarts the watchdog.
// RULE7: Watchdog held cleared while reset asserted.
// RULE8: Watchdog expiry gives one stretched reset pulse.
// RULE9: Undriven kick input disables the watchdog.
// RULE10: Active-high reset always complements active-low.
// RULE11: Unused manual reset is tied high.
// RULE12: Host kicks well inside the timeout.
// RULE13: Digital undervoltage input; internal counter timebase.
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH

`define CLK_FREQ_MHZ      250
`define STRETCH_PERIOD_MS 200
`define STRETCH_MIN_MS    140
`define WDT_TIMEOUT_MS    1600
`define STRETCH_CYCLES    (`STRETCH_PERIOD_MS * 1000 * `CLK_FREQ_MHZ)
`define WDT_CYCLES        (`WDT_TIMEOUT_MS * 1000 * `CLK_FREQ_MHZ)
`define CNT_W             32
`define ST_IDLE           3'h1
`define ST_HOLD           3'h2
`define ST_STRETCH        3'h4
`define OUT_RST_VAL       1'b1

`endif

/* File: rtl/supervisor_pkg.sv */
`include "supervisor_defines.svh"

package supervisor_pkg;
    typedef enum logic [2:0] {
        ST_IDLE    = `ST_IDLE,
        ST_HOLD    = `ST_HOLD,
        ST_STRETCH = `ST_STRETCH
    } stretch_state_e;
    typedef logic [`CNT_W-1:0] count_t;
endpackage

/* File: rtl/stretch_if.sv */
`timescale 1ns/1ps

interface stretch_if;
    logic hold;
    logic active;
    modport requester (output hold, input active);
    modport stretcher (input hold, output active);
endinterface

/* File: rtl/reset_stretcher.sv */
`timescale 1ns/1ps
`include "supervisor_defines.svh"

module reset_stretcher
    import supervisor_pkg::*;
#(
    parameter supervisor_pkg::count_t STRETCH_CYCLES = `CNT_W'(`STRETCH_CYCLES)
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    // Request and status
    stretch_if.stretcher sif
);
    import supervisor_pkg::*;

    stretch_state_e state;
    stretch_state_e next_state;
    count_t         cnt;
    count_t         next_cnt;

    wire logic cnt_done = (cnt == '0);

    // Any active source parks us in HOLD; release starts a full period
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            ST_IDLE: begin
                if (sif.hold) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!sif.hold) begin
                    next_state = ST_STRETCH; // RULE2 RULE4 RULE8
                    next_cnt   = STRETCH_CYCLES - 1'b1;
                end
            end
            ST_STRETCH: begin
                if (sif.hold) begin
                    next_state = ST_HOLD;
                end else if (cnt_done) begin
                    next_state = ST_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1; // RULE13
                end
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
    end

    // Reset lands in HOLD so outputs stretch after power-up too
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= ST_HOLD;
            cnt   <= '0;
        end else if (clk_en) begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    assign sif.active = (state != ST_IDLE) || sif.hold;

    ////////////////////////////////////////////////////////////////////////////////

    sequence s_release;
        (state == ST_HOLD) && !sif.hold;
    endsequence

    property p_stretch_load;
        @(posedge ref_clk) disable iff (sys_rst || !clk_en)
        s_release |=> (state == ST_STRETCH) && (cnt == STRETCH_CYCLES - 1'b1);
    endproperty
    a_stretch_load: assert property (p_stretch_load) // RULE2 RULE4
        else $error("stretch period not loaded on release");

    property p_stretch_count;
        @(posedge ref_clk) disable iff (sys_rst || !clk_en)
        (state == ST_STRETCH) && !cnt_done && !sif.hold |=>
            (cnt == $past(cnt) - 1'b1) && (state == ST_STRETCH);
    endproperty
    a_stretch_count: assert property (p_stretch_count) // RULE13
        else $error("stretch counter did not step down");

    property p_stretch_end;
        @(posedge ref_clk) disable iff (sys_rst || !clk_en)
        (state == ST_STRETCH) && cnt_done && !sif.hold |=> (state == ST_IDLE);
    endproperty
    a_stretch_end: assert property (p_stretch_end) // RULE8
        else $error("stretch did not end after its period");
endmodule

/* File: rtl/supervisor_watchdog_reset.sv */
`timescale 1ns/1ps
`include "supervisor_defines.svh"

module supervisor_watchdog_reset
    import supervisor_pkg::*;
#(
    parameter supervisor_pkg::count_t STRETCH_CYCLES = `CNT_W'(`STRETCH_CYCLES),
    parameter supervisor_pkg::count_t WDT_CYCLES     = `CNT_W'(`WDT_CYCLES)
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    // Supervised pins
    input  wire logic undervoltage_in,
    input  wire logic manual_reset_n_in,
    input  wire logic watchdog_kick_in,
    input  wire logic watchdog_kick_driven_in,
    // Reset outputs
    output logic      reset_out,
    output logic      reset_n_out
);
    import supervisor_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic uv_s1;
    logic uv_s2;
    logic mr_n_s1;
    logic mr_n_s2;
    logic kick_s1;
    logic kick_s2;
    logic kick_s3;
    logic drv_s1;
    logic drv_s2;

    // Reset values favour asserting reset until real pin levels arrive
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            uv_s1   <= '1;
            uv_s2   <= '1;
            mr_n_s1 <= '0;
            mr_n_s2 <= '0;
            drv_s1  <= '0;
            drv_s2  <= '0;
        end else if (clk_en) begin
            uv_s1   <= undervoltage_in;
            uv_s2   <= uv_s1;
            mr_n_s1 <= manual_reset_n_in;
            mr_n_s2 <= mr_n_s1;
            drv_s1  <= watchdog_kick_driven_in;
            drv_s2  <= drv_s1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            kick_s1 <= '0;
            kick_s2 <= '0;
            kick_s3 <= '0;
        end else if (clk_en) begin
            kick_s1 <= watchdog_kick_in;
            kick_s2 <= kick_s1;
            kick_s3 <= kick_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog

    stretch_if sif ();

    count_t     wdt_count;
    count_t     next_wdt_count;
    wire logic  kick_edge  = kick_s2 ^ kick_s3; // RULE6
    // Armed from registered levels only: the stretcher's active flag feeds
    // back through wdt_expire and would close a combinational loop
    wire logic  wdt_armed  = drv_s2 && !reset_out && !uv_s2 && mr_n_s2; // RULE9 RULE7
    wire logic  wdt_at_end = (wdt_count == WDT_CYCLES - 1'b1);
    wire logic  wdt_expire = wdt_armed && !kick_edge && wdt_at_end; // RULE5
    wire logic  wdt_clear  = !wdt_armed || kick_edge || wdt_expire;

    assign next_wdt_count = wdt_clear ? '0 : wdt_count + 1'b1; // RULE6 RULE7

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wdt_count <= '0;
        end else if (clk_en) begin
            wdt_count <= next_wdt_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset combining and stretching

    // Comparator result is taken as already hysteretic; no filtering here
    wire logic mr_active = !mr_n_s2; // RULE3
    assign sif.hold = uv_s2 || mr_active || wdt_expire; // RULE1 RULE3 RULE8 RULE13

    reset_stretcher #(
        .STRETCH_CYCLES (STRETCH_CYCLES)
    ) u_stretcher (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .sif     (sif)
    );

    // Both outputs come from one decision so they can never disagree
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reset_out   <= `OUT_RST_VAL;
            reset_n_out <= ~`OUT_RST_VAL;
        end else if (clk_en) begin
            reset_out   <= sif.active; // RULE10
            reset_n_out <= ~sif.active; // RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_complement;
        @(posedge ref_clk) disable iff (sys_rst)
        reset_out == !reset_n_out;
    endproperty
    a_complement: assert property (p_complement) // RULE10
        else $error("reset outputs not complementary");

    property p_uv_assert;
        @(posedge ref_clk) disable iff (sys_rst || !clk_en)
        uv_s2 |=> reset_out && !reset_n_out;
    endproperty
    a_uv_assert: assert property (p_uv_assert) // RULE1
        else $error("undervoltage did not assert reset");

    sequence s_mr_held;
        mr_active [*2];
    endsequence

    property p_mr_assert;
        @(posedge ref_clk) disable iff (sys_rst || !clk_en)
        s_mr_held |-> reset_out;
    endproperty
    a_mr_assert: assert property (p_mr_assert) // RULE3
        else $error("manual reset low did not keep reset asserted");

    property p_wdt_cleared_in_reset;
        @(posedge ref_clk) disable iff (sys_rst || !clk_en)
        reset_out |-> (wdt_count == '0);
    endproperty
    a_wdt_cleared_in_reset: assert property (p_wdt_cleared_in_reset) // RULE7
        else $error("watchdog counted while reset asserted");

    property p_kick_restart;
        @(posedge ref_clk) disable iff (sys_rst || !clk_en)
        kick_edge |=> (wdt_count == '0);
    endproperty
    a_kick_restart: assert property (p_kick_restart) // RULE6
        else $error("kick edge did not restart watchdog");

    property p_float_disables;
        @(posedge ref_clk) disable iff (sys_rst || !clk_en)
        !drv_s2 |-> !wdt_expire ##1 (wdt_count == '0);
    endproperty
    a_float_disables: assert property (p_float_disables) // RULE9
        else $error("watchdog ran with kick input undriven");

    sequence s_expiry;
        wdt_armed && !kick_edge && wdt_at_end;
    endsequence

    property p_expiry_resets;
        @(posedge ref_clk) disable iff (sys_rst || !clk_en)
        s_expiry |=> reset_out ##1 reset_out;
    endproperty
    a_expiry_resets: assert property (p_expiry_resets) // RULE5 RULE8
        else $error("watchdog expiry did not assert reset");

    property p_count_steps;
        @(posedge ref_clk) disable iff (sys_rst || !clk_en)
        !wdt_clear |=> (wdt_count == $past(wdt_count) + 1'b1);
    endproperty
    a_count_steps: assert property (p_count_steps) // RULE5
        else $error("watchdog counter did not advance");

    property p_release_quiet;
        @(posedge ref_clk) disable iff (sys_rst || !clk_en)
        !reset_out ##1 !reset_out |-> !$past(sif.hold);
    endproperty
    a_release_quiet: assert property (p_release_quiet) // RULE1 RULE3
        else $error("reset released while a source was active");

    property p_expire_single;
        @(posedge ref_clk) disable iff (sys_rst || !clk_en)
        wdt_expire |=> !wdt_expire;
    endproperty
    a_expire_single: assert property (p_expire_single) // RULE8
        else $error("watchdog expiry lasted more than one cycle");

    sequence s_held_two;
        reset_out ##1 reset_out;
    endsequence

    property p_uv_release;
        @(posedge ref_clk) disable iff (sys_rst || !clk_en)
        $fell(uv_s2) |-> s_held_two;
    endproperty
    a_uv_release: assert property (p_uv_release) // RULE2
        else $error("reset released as soon as undervoltage cleared");

    property p_mr_release;
        @(posedge ref_clk) disable iff (sys_rst || !clk_en)
        $fell(mr_active) |-> s_held_two;
    endproperty
    a_mr_release: assert property (p_mr_release) // RULE4
        else $error("reset released as soon as manual reset returned high");

    // A low clock enable must leave every stage where it was
    property p_freeze;
        @(posedge ref_clk) disable iff (sys_rst)
        !clk_en |=> $stable(reset_out) && $stable(wdt_count) && $stable(uv_s2);
    endproperty
    a_freeze: assert property (p_freeze) // RULE13
        else $error("state moved while clock enable was low");
endmodule

/* File: sim/host_kick_model.sv */
`timescale 1ns/1ps

module host_kick_model (
    // Clock
    input  wire logic       ref_clk,
    // Behaviour: 0 pin released, 1 kicking, 2 driven but silent
    input  wire logic [1:0] mode,
    input  wire logic [7:0] period,
    // Kick pin
    output logic            watchdog_kick_in,
    output logic            watchdog_kick_driven_in
);
    logic [7:0] cnt;
    logic       last;

    initial begin
        cnt = 8'h00;
        last = 1'b0;
        watchdog_kick_in = 1'b0;
        watchdog_kick_driven_in = 1'b0;
    end

    always @(negedge ref_clk) begin
        watchdog_kick_driven_in <= (mode != 2'h0);
        if (mode == 2'h0) begin
            // No pull on the pin, so a floating level must not look like the last one
            watchdog_kick_in <= ~last;
        end else if (mode == 2'h1 && cnt >= period) begin
            cnt <= 8'h00;
            last <= ~last;
            watchdog_kick_in <= ~last;
        end else begin
            cnt <= cnt + 8'h01;
            watchdog_kick_in <= last;
        end
    end
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps

module tb;
    import supervisor_pkg::*;

    localparam int S = 20;
    localparam int W = 60;

    logic       ref_clk           = 1'b0;
    logic       sys_rst           = 1'b1;
    logic       clk_en            = 1'b1;
    logic       undervoltage_in   = 1'b0;
    logic       manual_reset_n_in = 1'b1;
    logic [1:0] mode              = 2'h0;
    logic [7:0] period            = 8'h04;
    logic       kick;
    logic       driven;
    logic       reset_out;
    logic       reset_n_out;
    int         err_count         = 0;
    int         n_tests           = 0;
    int         cycles            = 0;
    int         n;
    int         m;

    always #2 ref_clk = ~ref_clk;

    supervisor_watchdog_reset #(
        .STRETCH_CYCLES (32'h14),
        .WDT_CYCLES     (32'h3c)
    ) i_dut (
        .ref_clk                 (ref_clk),
        .sys_rst                 (sys_rst),
        .clk_en                  (clk_en),
        .undervoltage_in         (undervoltage_in),
        .manual_reset_n_in       (manual_reset_n_in),
        .watchdog_kick_in        (kick),
        .watchdog_kick_driven_in (driven),
        .reset_out               (reset_out),
        .reset_n_out             (reset_n_out)
    );

    host_kick_model i_host (
        .ref_clk                 (ref_clk),
        .mode                    (mode),
        .period                  (period),
        .watchdog_kick_in        (kick),
        .watchdog_kick_driven_in (driven)
    );

    ////////////////////////////////////////////////////////////////////////////

    task automatic check(input string name, input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", name, exp, seen);
        end
    endtask

    task report_and_stop;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Bounded so a stuck output shows up as a wrong count, not a hang
    task automatic wait_lvl(input logic lvl, output int k);
        k = 0;
        while (reset_out !== lvl && k < 500) begin
            @(negedge ref_clk);
            k++;
        end
    endtask

    task automatic pulse(input logic use_uv, input int len);
        int k;
        @(negedge ref_clk);
        if (use_uv) undervoltage_in = 1'b1;
        else manual_reset_n_in = 1'b0;
        repeat (3) @(negedge ref_clk);
        for (int i = 0; i < len; i++) begin
            check("held", reset_out, 1'b1);
            @(negedge ref_clk);
        end
        undervoltage_in = 1'b0;
        manual_reset_n_in = 1'b1;
        wait_lvl(1'b0, k);
        if (use_uv) check("uv_stretch", k >= S && k <= S + 5, 1'b1);
        else check("mr_stretch", k >= S && k <= S + 5, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    always @(negedge ref_clk) begin
        if (cycles > 1) check("complement", reset_n_out, ~reset_out);
    end

    initial begin
        void'($urandom(32'hec9e));
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        wait_lvl(1'b0, n);
        check("por_stretch", n >= S && n <= S + 8, 1'b1);
        pulse(1'b1, 1);
        pulse(1'b0, 1);
        repeat (6) pulse(1'($urandom_range(1, 0)), $urandom_range(40, 1));
        // Clock enable low in mid-stretch delays the release by as many edges
        m = $urandom_range(20, 1);
        manual_reset_n_in = 1'b0;
        repeat (4) @(negedge ref_clk);
        manual_reset_n_in = 1'b1;
        repeat (6) @(negedge ref_clk);
        clk_en = 1'b0;
        repeat (m) @(negedge ref_clk);
        check("frozen", reset_out, 1'b1);
        clk_en = 1'b1;
        wait_lvl(1'b0, n);
        check("freeze_stretch", n == S + 4 - 6, 1'b1);
        // A long manual reset must not let the silent watchdog run meanwhile
        mode = 2'h2;
        pulse(1'b0, W + 20);
        wait_lvl(1'b1, n);
        check("wdog_gap", n >= W - 2 && n <= W + 6, 1'b1);
        wait_lvl(1'b0, m);
        check("wdog_pulse", m >= S && m <= S + 5, 1'b1);
        wait_lvl(1'b1, n);
        check("wdog_stuck", n >= W - 2 && n <= W + 6, 1'b1);
        wait_lvl(1'b0, m);
        mode = 2'h1;
        for (int i = 0; i < 4; i++) begin
            period = 8'($urandom_range(W / 2, 1));
            repeat (2 * W) begin
                @(negedge ref_clk);
                check("kicked", reset_out, 1'b0);
            end
        end
        mode = 2'h0;
        repeat (4 * W) begin
            @(negedge ref_clk);
            check("pin_released", reset_out, 1'b0);
        end
        report_and_stop();
    end
endmodule
